/* ctw_pkg.sv */
// Contract
// - Long dominant transmit input disables the transmitter
// - Transmitter stays off until transmit rising edge
// - Over-temperature blocks driver, bus stays recessive biased
// - Receive path keeps working during over-temperature
// - Unconnected transmit input reads as recessive
// - Unconnected standby select means standby mode
// - Standby select low gives normal mode
// - Normal mode drives bus and mirrors receiver
// - Standby disables driver and receiver, monitor on
// - Wake monitor accepts states longer than filter
// - Wake attempt starts on first valid dominant
// - Other traffic does not reset wake attempt
// - Receive output low after dominant-recessive-dominant in window
// - Standby keeps receive output high until wake
// - Standby leaves bus lines undriven, weak pull-down
// - Settling time after undervoltage before normal mode; code skips it, going standby to normal, if select was high during undervoltage
package ctw_pkg;

   localparam int CTW_CLK_PERIOD_NS = 25;
   localparam int CTW_CNT_W         = 20;

   localparam int CTW_DOM_TIME_NS   = 1000000;
   localparam int CTW_WK_FILT_NS    = 1000;
   localparam int CTW_WK_WIN_NS     = 1000000;
   localparam int CTW_MODE_TIME_NS  = 20000;

   localparam int CTW_DOM_CYC     = (CTW_DOM_TIME_NS + CTW_CLK_PERIOD_NS - 1) / CTW_CLK_PERIOD_NS;
   localparam int CTW_WK_FILT_CYC = (CTW_WK_FILT_NS + CTW_CLK_PERIOD_NS - 1) / CTW_CLK_PERIOD_NS;
   localparam int CTW_WK_WIN_CYC  = CTW_WK_WIN_NS / CTW_CLK_PERIOD_NS;
   localparam int CTW_MODE_CYC    = (CTW_MODE_TIME_NS + CTW_CLK_PERIOD_NS - 1) / CTW_CLK_PERIOD_NS;

   localparam logic [3:0] CTW_ADDR_CTRL   = 4'h0;
   localparam logic [3:0] CTW_ADDR_STATUS = 4'h4;

   localparam int CTW_CTRL_WAKE_EN = 0;
   localparam int CTW_CTRL_DOM_EN  = 1;
   localparam logic [7:0] CTW_CTRL_RST = 8'h03;

   localparam int CTW_ST_STANDBY  = 0;
   localparam int CTW_ST_DOMFLT   = 1;
   localparam int CTW_ST_OVERTEMP = 2;
   localparam int CTW_ST_WAKE     = 3;
   localparam int CTW_ST_SETTLE   = 4;
   localparam int CTW_ST_OFF      = 5;
   localparam int CTW_ST_WSTATE   = 6;

   typedef struct packed {
      logic txd;
      logic stb;
      logic bus_dom;
      logic mon_dom;
      logic ot;
      logic uv;
   } ctw_pins_t;

   localparam ctw_pins_t CTW_PINS_RST = '{txd: 1'b1, stb: 1'b1, bus_dom: 1'b0,
                                          mon_dom: 1'b0, ot: 1'b0, uv: 1'b0};

   typedef struct packed {
      logic hi_o;
      logic hi_oe_n;
      logic lo_o;
      logic lo_oe_n;
      logic bias_en;
      logic pulldown_en;
   } ctw_bus_drv_t;

   typedef enum logic [1:0] {CTW_M_OFF, CTW_M_SETTLE, CTW_M_NORMAL, CTW_M_STANDBY} ctw_mode_t;
   typedef enum logic [1:0] {CTW_W_IDLE, CTW_W_DOM1, CTW_W_REC} ctw_wake_t;

endpackage

/* ctw_pin_sync.sv */
`timescale 1ns/10ps
module ctw_pin_sync
   import ctw_pkg::*;
(
   input  wire logic      clk_sys,
   input  wire logic      rst_n,
   input  wire logic      clk_en,
   input  wire ctw_pins_t pins_async,
   output ctw_pins_t      pins_sync
);

   ctw_pins_t s1_r;
   ctw_pins_t s2_r;
   ctw_pins_t s3_r;
   ctw_pins_t q_r;
   ctw_pins_t q_nxt;

   // Update only where second and third stage agree
   assign q_nxt = (s3_r & ~(s2_r ^ s3_r)) | (q_r & (s2_r ^ s3_r));

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s1_r <= CTW_PINS_RST;
         s2_r <= CTW_PINS_RST;
         s3_r <= CTW_PINS_RST;
         q_r  <= CTW_PINS_RST;
      end else if (clk_en) begin
         s1_r <= pins_async;
         s2_r <= s1_r;
         s3_r <= s2_r;
         q_r  <= q_nxt;
      end
   end

   assign pins_sync = q_r;

endmodule

/* ctw_core.sv */
`timescale 1ns/10ps
module ctw_core
   import ctw_pkg::*;
#(
   parameter int CNT_W       = CTW_CNT_W,
   parameter int DOM_CYC     = CTW_DOM_CYC,
   parameter int WK_FILT_CYC = CTW_WK_FILT_CYC,
   parameter int WK_WIN_CYC  = CTW_WK_WIN_CYC,
   parameter int MODE_CYC    = CTW_MODE_CYC
)
(
   input  wire logic   clk_sys,
   input  wire logic   rst_n,
   input  wire logic   clk_en,
   input  wire logic   txd_level,
   input  wire logic   txd_driven,
   input  wire logic   standby_select_level,
   input  wire logic   standby_select_driven,
   input  wire logic   bus_rx_dominant,
   input  wire logic   bus_mon_dominant,
   input  wire logic   overtemp_flag,
   input  wire logic   undervolt_flag,
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic   reg_wr,
   input  wire logic   reg_rd,
   output logic [7:0]  reg_rdata,
   output logic        rxd,
   output logic        bus_high_line_o,
   output logic        bus_high_line_oe_n,
   output logic        bus_low_line_o,
   output logic        bus_low_line_oe_n,
   output logic        bus_bias_en,
   output logic        bus_pulldown_en,
   output logic        main_rx_en,
   output logic        monitor_en
);

   localparam logic [CNT_W-1:0] DOM_LIM  = CNT_W'(DOM_CYC);
   localparam logic [CNT_W-1:0] FILT_LIM = CNT_W'(WK_FILT_CYC);
   localparam logic [CNT_W-1:0] WIN_LIM  = CNT_W'(WK_WIN_CYC);
   localparam logic [CNT_W-1:0] MODE_LIM = CNT_W'(MODE_CYC);
   localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

   ctw_pins_t    pins_raw;
   ctw_pins_t    pins;
   ctw_bus_drv_t drv_nxt;
   ctw_bus_drv_t drv_r;

   ctw_mode_t        mode_r;
   ctw_mode_t        mode_nxt;
   logic [CNT_W-1:0] settle_cnt_r;
   logic [CNT_W-1:0] settle_cnt_nxt;

   logic [CNT_W-1:0] dom_cnt_r;
   logic [CNT_W-1:0] dom_cnt_nxt;
   logic             dom_fault_r;
   logic             dom_fault_nxt;
   logic             txd_prev_r;

   logic             flt_lvl_r;
   logic [CNT_W-1:0] flt_cnt_r;
   logic [CNT_W-1:0] flt_cnt_nxt;
   ctw_wake_t        wake_st_r;
   ctw_wake_t        wake_st_nxt;
   logic [CNT_W-1:0] win_cnt_r;
   logic [CNT_W-1:0] win_cnt_nxt;
   logic             wake_r;
   logic             wake_nxt;

   logic [7:0] ctrl_r;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic       rxd_r;
   logic       rxd_nxt;

   // Floating pins read high
   assign pins_raw.txd     = txd_driven ? txd_level : 1'b1;
   assign pins_raw.stb     = standby_select_driven ? standby_select_level : 1'b1;
   assign pins_raw.bus_dom = bus_rx_dominant;
   assign pins_raw.mon_dom = bus_mon_dominant;
   assign pins_raw.ot      = overtemp_flag;
   assign pins_raw.uv      = undervolt_flag;

   ctw_pin_sync u_sync (
      .clk_sys    (clk_sys),
      .rst_n      (rst_n),
      .clk_en     (clk_en),
      .pins_async (pins_raw),
      .pins_sync  (pins)
   );

   // Mode selection
   wire is_normal   = (mode_r == CTW_M_NORMAL);
   wire is_standby  = (mode_r == CTW_M_STANDBY);
   wire settle_done = (settle_cnt_r >= MODE_LIM);

   always_comb begin
      mode_nxt       = mode_r;
      settle_cnt_nxt = settle_cnt_r;
      case (mode_r)
         CTW_M_OFF: begin
            settle_cnt_nxt = '0;
            if (!pins.uv) begin
               mode_nxt = CTW_M_SETTLE;
            end else if (pins.stb) begin
               mode_nxt = CTW_M_STANDBY;
            end
         end
         CTW_M_SETTLE: begin
            settle_cnt_nxt = settle_cnt_r + CNT_ONE;
            if (pins.uv) begin
               mode_nxt = CTW_M_OFF;
            end else if (settle_done) begin
               mode_nxt = pins.stb ? CTW_M_STANDBY : CTW_M_NORMAL;
            end
         end
         CTW_M_NORMAL: begin
            if (pins.uv) begin
               mode_nxt = CTW_M_OFF;
            end else if (pins.stb) begin
               mode_nxt = CTW_M_STANDBY;
            end
         end
         CTW_M_STANDBY: begin
            if (pins.uv && !pins.stb) begin
               mode_nxt = CTW_M_OFF;
            end else if (!pins.uv && !pins.stb) begin
               mode_nxt = CTW_M_NORMAL;
            end
         end
         default: begin
            mode_nxt = CTW_M_OFF;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         mode_r       <= CTW_M_SETTLE;
         settle_cnt_r <= '0;
      end else if (clk_en) begin
         mode_r       <= mode_nxt;
         settle_cnt_r <= settle_cnt_nxt;
      end
   end

   // Dominant timeout
   wire dom_en   = ctrl_r[CTW_CTRL_DOM_EN];
   wire txd_rise = pins.txd && !txd_prev_r;
   wire dom_hit  = dom_en && is_normal && !pins.txd && (dom_cnt_r >= DOM_LIM);

   assign dom_cnt_nxt = pins.txd ? '0 :
                        (dom_cnt_r >= DOM_LIM) ? dom_cnt_r : dom_cnt_r + CNT_ONE;
   assign dom_fault_nxt = dom_hit ? 1'b1 :
                          txd_rise ? 1'b0 : dom_fault_r;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         dom_cnt_r   <= '0;
         dom_fault_r <= 1'b0;
         txd_prev_r  <= 1'b1;
      end else if (clk_en) begin
         dom_cnt_r   <= dom_cnt_nxt;
         dom_fault_r <= dom_fault_nxt;
         txd_prev_r  <= pins.txd;
      end
   end

   // Bus drivers
   wire tx_dominant = is_normal && !pins.txd && !dom_fault_r && !dom_hit
                      && !pins.ot;

   assign drv_nxt.hi_o        = 1'b1;
   assign drv_nxt.lo_o        = 1'b0;
   assign drv_nxt.hi_oe_n     = !tx_dominant;
   assign drv_nxt.lo_oe_n     = !tx_dominant;
   assign drv_nxt.bias_en     = is_normal;
   assign drv_nxt.pulldown_en = is_standby;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         drv_r <= '{hi_o: 1'b1, hi_oe_n: 1'b1, lo_o: 1'b0, lo_oe_n: 1'b1,
                    bias_en: 1'b0, pulldown_en: 1'b0};
      end else if (clk_en) begin
         drv_r <= drv_nxt;
      end
   end

   assign bus_high_line_o    = drv_r.hi_o;
   assign bus_high_line_oe_n = drv_r.hi_oe_n;
   assign bus_low_line_o     = drv_r.lo_o;
   assign bus_low_line_oe_n  = drv_r.lo_oe_n;
   assign bus_bias_en        = drv_r.bias_en;
   assign bus_pulldown_en    = drv_r.pulldown_en;
   assign main_rx_en         = is_normal;
   assign monitor_en         = is_standby;

   // Wake filter
   wire mon_change = (pins.mon_dom != flt_lvl_r);
   wire flt_full   = (flt_cnt_r >= FILT_LIM);

   assign flt_cnt_nxt = mon_change ? '0 :
                        flt_full ? flt_cnt_r : flt_cnt_r + CNT_ONE;

   wire flt_valid = is_standby && !mon_change && (flt_cnt_nxt == FILT_LIM)
                    && !flt_full;
   wire valid_dom = flt_valid && flt_lvl_r;
   wire valid_rec = flt_valid && !flt_lvl_r;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         flt_lvl_r <= 1'b0;
         flt_cnt_r <= '0;
      end else if (clk_en) begin
         flt_lvl_r <= pins.mon_dom;
         flt_cnt_r <= flt_cnt_nxt;
      end
   end

   // Wake sequence
   wire wake_en     = ctrl_r[CTW_CTRL_WAKE_EN];
   wire win_expired = (win_cnt_r >= WIN_LIM);

   always_comb begin
      wake_st_nxt = wake_st_r;
      win_cnt_nxt = win_cnt_r + CNT_ONE;
      wake_nxt    = wake_r;
      if (!is_standby || !wake_en) begin
         wake_st_nxt = CTW_W_IDLE;
         win_cnt_nxt = '0;
         wake_nxt    = is_standby && wake_r;
      end else begin
         case (wake_st_r)
            CTW_W_IDLE: begin
               win_cnt_nxt = '0;
               if (valid_dom && !wake_r) begin
                  wake_st_nxt = CTW_W_DOM1;
               end
            end
            CTW_W_DOM1: begin
               if (win_expired) begin
                  wake_st_nxt = CTW_W_IDLE;
               end else if (valid_rec) begin
                  wake_st_nxt = CTW_W_REC;
               end
            end
            CTW_W_REC: begin
               if (win_expired) begin
                  wake_st_nxt = CTW_W_IDLE;
               end else if (valid_dom) begin
                  wake_st_nxt = CTW_W_IDLE;
                  wake_nxt    = 1'b1;
               end
            end
            default: begin
               wake_st_nxt = CTW_W_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         wake_st_r <= CTW_W_IDLE;
         win_cnt_r <= '0;
         wake_r    <= 1'b0;
      end else if (clk_en) begin
         wake_st_r <= wake_st_nxt;
         win_cnt_r <= win_cnt_nxt;
         wake_r    <= wake_nxt;
      end
   end

   // Receive output
   assign rxd_nxt = is_normal ? !pins.bus_dom :
                    is_standby ? !wake_r :
                    1'b1;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rxd_r <= 1'b1;
      end else if (clk_en) begin
         rxd_r <= rxd_nxt;
      end
   end

   assign rxd = rxd_r;

   // Register port
   wire ctrl_sel   = (reg_addr == CTW_ADDR_CTRL);
   wire status_sel = (reg_addr == CTW_ADDR_STATUS);

   wire [7:0] status_word = {wake_st_r, (mode_r == CTW_M_OFF),
                             (mode_r == CTW_M_SETTLE), wake_r, pins.ot,
                             dom_fault_r, is_standby};

   assign rdata_nxt = !reg_rd ? 8'h00 :
                      ctrl_sel ? ctrl_r :
                      status_sel ? status_word : 8'h00;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ctrl_r  <= CTW_CTRL_RST;
         rdata_r <= 8'h00;
      end else if (clk_en) begin
         rdata_r <= rdata_nxt;
         if (reg_wr && ctrl_sel) begin
            ctrl_r <= {6'h00, reg_wdata[1:0]};
         end
      end
   end

   assign reg_rdata = rdata_r;

endmodule

/* ctw_core_properties.sv */
`timescale 1ns/10ps
module ctw_core_chk
   import ctw_pkg::*;
#(
   parameter int DOM_CYC = CTW_DOM_CYC
)
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic txd_level,
   input wire logic txd_driven,
   input wire logic standby_select_driven,
   input wire logic overtemp_flag,
   input wire logic bus_high_line_o,
   input wire logic bus_high_line_oe_n,
   input wire logic bus_low_line_o,
   input wire logic bus_low_line_oe_n,
   input wire logic bus_bias_en,
   input wire logic bus_pulldown_en,
   input wire logic main_rx_en,
   input wire logic monitor_en
);
   localparam logic [15:0] DOM_LIM = 16'(DOM_CYC + 2);
   logic [15:0] drv_run_r;

   // Length of the current dominant drive
   always_ff @(posedge clk_sys) begin
      if (!rst_n || bus_high_line_oe_n) drv_run_r <= 16'h0000;
      else drv_run_r <= drv_run_r + 16'h0001;
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   sequence s_txd_rec; txd_driven && txd_level; endsequence
   sequence s_txd_open; !txd_driven; endsequence
   sequence s_sel_open; !standby_select_driven; endsequence

   a_dom_release: assert property (drv_run_r <= DOM_LIM)
      else $error("dominant drive too long");
   a_rec_idle: assert property (s_txd_rec [*8] |-> bus_high_line_oe_n)
      else $error("driving while transmit recessive");
   a_open_txd: assert property (s_txd_open [*8] |-> bus_high_line_oe_n && bus_low_line_oe_n)
      else $error("floating transmit input drives bus");
   a_open_select: assert property (s_sel_open [*8] |-> !main_rx_en)
      else $error("floating select not standby");
   a_hot_off: assert property (overtemp_flag [*8] |-> bus_high_line_oe_n)
      else $error("driver on while hot");
   a_normal_bias: assert property (main_rx_en [*3] |-> bus_bias_en)
      else $error("no bias in normal mode");
   a_standby_pull: assert property (monitor_en [*3] |-> bus_pulldown_en && !bus_bias_en
                                    && bus_high_line_oe_n)
      else $error("standby bus not released");
   a_drive_normal: assert property (!bus_high_line_oe_n |-> main_rx_en || $past(main_rx_en))
      else $error("driving outside normal mode");
   a_pair_lines: assert property (bus_high_line_oe_n == bus_low_line_oe_n && bus_high_line_o
                                  && !bus_low_line_o)
      else $error("bus lines not paired");
   a_mode_excl: assert property (!(main_rx_en && monitor_en))
      else $error("receiver and monitor both on");
endmodule

bind ctw_core ctw_core_chk #(.DOM_CYC(DOM_CYC)) u_chk (
   .clk_sys(clk_sys), .rst_n(rst_n), .txd_level(txd_level), .txd_driven(txd_driven),
   .standby_select_driven(standby_select_driven), .overtemp_flag(overtemp_flag),
   .bus_high_line_o(bus_high_line_o), .bus_high_line_oe_n(bus_high_line_oe_n),
   .bus_low_line_o(bus_low_line_o), .bus_low_line_oe_n(bus_low_line_oe_n),
   .bus_bias_en(bus_bias_en), .bus_pulldown_en(bus_pulldown_en),
   .main_rx_en(main_rx_en), .monitor_en(monitor_en));

/* ctw_ctrl_model.sv */
`timescale 1ns/10ps
module ctw_ctrl_model (
   input  wire logic clk_sys,
   input  wire logic tx_bit,
   input  wire logic tx_float,
   input  wire logic sby_req,
   input  wire logic sby_float,
   input  wire logic wake_ack,
   input  wire logic rxd,
   output logic      txd_level,
   output logic      txd_driven,
   output logic      sby_level,
   output logic      sby_driven
);
   logic woke_r;

   initial begin
      txd_level = 1'b1;
      txd_driven = 1'b1;
      sby_level = 1'b1;
      sby_driven = 1'b1;
      woke_r = 1'b0;
   end

   // Floating pins toggle so a stale level is never seen
   always @(posedge clk_sys) begin
      txd_driven <= !tx_float;
      txd_level  <= tx_float ? !txd_level : tx_bit;
      sby_driven <= !sby_float;
      sby_level  <= sby_float ? !sby_level : sby_req && !woke_r;
      woke_r     <= wake_ack && (woke_r || (!rxd && sby_level));
   end
endmodule

/* ctw_core_tb.sv */
`timescale 1ns/10ps
module ctw_core_tb
   import ctw_pkg::*;
;
   logic clk_sys = 0, rst_n = 0, tx_bit = 1, tx_float = 0, sby_req = 1, sby_float = 0;
   logic wake_ack = 0, rx_dom = 0, mon_dom = 0, ot = 0, uv = 0, rd = 0, wr = 0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata;
   logic txd_l, txd_d, sby_l, sby_d, rxd, hi_o, hi_oe_n, lo_o, lo_oe_n, bias, pull, main_rx, mon_en;
   logic [31:0] rng = 32'h94f1;
   int err_count = 0;
   int n_tests = 0;

   always #12.5 clk_sys = ~clk_sys;

   ctw_ctrl_model u_ctrl (.clk_sys(clk_sys), .tx_bit(tx_bit), .tx_float(tx_float),
      .sby_req(sby_req), .sby_float(sby_float), .wake_ack(wake_ack), .rxd(rxd),
      .txd_level(txd_l), .txd_driven(txd_d), .sby_level(sby_l), .sby_driven(sby_d));

   ctw_core #(.DOM_CYC(20), .WK_FILT_CYC(4), .WK_WIN_CYC(100), .MODE_CYC(8)) dut (
      .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(1'b1), .txd_level(txd_l), .txd_driven(txd_d),
      .standby_select_level(sby_l), .standby_select_driven(sby_d), .bus_rx_dominant(rx_dom),
      .bus_mon_dominant(mon_dom), .overtemp_flag(ot), .undervolt_flag(uv), .reg_addr(addr),
      .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .rxd(rxd),
      .bus_high_line_o(hi_o), .bus_high_line_oe_n(hi_oe_n), .bus_low_line_o(lo_o),
      .bus_low_line_oe_n(lo_oe_n), .bus_bias_en(bias), .bus_pulldown_en(pull),
      .main_rx_en(main_rx), .monitor_en(mon_en));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   function automatic logic exp_oe_n(input logic tx, input logic hot);
      return tx | hot;
   endfunction

   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   task automatic wrap_up();
      $display("checks=%0d errors=%0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cb(input logic got, input logic exp);
      chk({7'h00, got}, {7'h00, exp});
   endtask

   task automatic wait_main(input logic exp);
      repeat (200) if (main_rx !== exp) step(1);
      cb(main_rx, exp);
      if (main_rx !== exp) wrap_up();
   endtask

   task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
      rd <= 1'b1;
      addr <= a;
      step(1);
      rd <= 1'b0;
      step(1);
      chk(rdata, e);
   endtask

   task automatic mon(input logic lvl, input int n);
      mon_dom <= lvl;
      step(n);
   endtask

   initial begin
      step(6);
      rst_n <= 1'b1;
      sby_req <= 1'b0;
      wait_main(1'b1);
      step(2);
      cb(bias, 1'b1);
      rd_reg(CTW_ADDR_CTRL, CTW_CTRL_RST);
      wr <= 1'b1;
      addr <= 4'h8;
      wdata <= 8'hff;
      step(1);
      wr <= 1'b0;
      rd_reg(4'h8, 8'h00);
      $display("test registers done");
      for (int i = 0; i < 40; i++) begin
         rng = xs(rng);
         tx_bit <= rng[0] | !tx_bit;
         rx_dom <= rng[1];
         step(8);
         cb(hi_oe_n, exp_oe_n(tx_bit, 1'b0));
         cb(rxd, !rx_dom);
      end
      tx_bit <= 1'b1;
      rx_dom <= 1'b0;
      step(8);
      $display("test random traffic done");
      tx_bit <= 1'b0;
      step(30);
      cb(hi_oe_n, 1'b1);
      rd_reg(CTW_ADDR_STATUS, 8'h02);
      tx_bit <= 1'b1;
      step(4);
      tx_bit <= 1'b0;
      step(8);
      cb(hi_oe_n, 1'b0);
      ot <= 1'b1;
      rx_dom <= 1'b1;
      step(8);
      cb(hi_oe_n, exp_oe_n(tx_bit, ot));
      cb(bias, 1'b1);
      cb(rxd, 1'b0);
      tx_bit <= 1'b1;
      ot <= 1'b0;
      rx_dom <= 1'b0;
      step(8);
      $display("test protection done");
      sby_req <= 1'b1;
      wait_main(1'b0);
      step(3);
      cb(mon_en, 1'b1);
      cb(pull, 1'b1);
      tx_bit <= 1'b0;
      step(8);
      cb(hi_oe_n, 1'b1);
      cb(rxd, 1'b1);
      tx_bit <= 1'b1;
      mon(1'b1, 2);
      mon(1'b0, 10);
      mon(1'b1, 10);
      cb(rxd, 1'b1);
      mon(1'b0, 10);
      mon(1'b1, 2);
      mon(1'b0, 10);
      cb(rxd, 1'b1);
      mon(1'b1, 12);
      cb(rxd, 1'b0);
      wake_ack <= 1'b1;
      wait_main(1'b1);
      wake_ack <= 1'b0;
      wait_main(1'b0);
      step(3);
      cb(rxd, 1'b1);
      mon(1'b1, 10);
      mon(1'b0, 130);
      mon(1'b1, 10);
      mon(1'b0, 10);
      cb(rxd, 1'b1);
      mon(1'b1, 12);
      cb(rxd, 1'b0);
      mon(1'b0, 4);
      $display("test wake done");
      sby_req <= 1'b0;
      wait_main(1'b1);
      sby_float <= 1'b1;
      wait_main(1'b0);
      sby_float <= 1'b0;
      wait_main(1'b1);
      tx_float <= 1'b1;
      step(10);
      cb(hi_oe_n, 1'b1);
      tx_float <= 1'b0;
      uv <= 1'b1;
      step(10);
      cb(main_rx, 1'b0);
      uv <= 1'b0;
      step(6);
      cb(main_rx, 1'b0);
      wait_main(1'b1);
      $display("test pins and supply done");
      wrap_up();
   end
endmodule
